// ==== press_tally_pkg.sv ====
// Shared constants and types for the press stroke counter bank
package press_tally_pkg;
  localparam int TALLY_W = 24;
  localparam int ANGLE_W = 9;
  localparam int PULSE_W = 14;
  localparam int NUM_GROUPS = 3;
  localparam int NUM_TALLY = 6;
  // Tally indices
  localparam logic [2:0] IDX_STROKE = 3'h0;
  localparam logic [2:0] IDX_GOOD = 3'h1;
  localparam logic [2:0] IDX_LIFE = 3'h2;
  localparam logic [2:0] IDX_GRP0 = 3'h3;
  // Cam channels driven by the groups
  localparam logic [3:0] CAM_CH_GRP0 = 4'h6;
  localparam logic [3:0] CAM_CH_GRP1 = 4'h7;
  localparam logic [3:0] CAM_CH_GRP2 = 4'h8;
  // Reset values and pulse length limit
  localparam logic [ANGLE_W-1:0] ANGLE_RST = 9'h10e;
  localparam logic [TALLY_W-1:0] COUNT_RST = 24'h000000;
  localparam logic [TALLY_W-1:0] PRESET_RST = 24'h000000;
  localparam logic [PULSE_W-1:0] PULSE_MAX_MS = 14'h270f;
  localparam logic [PULSE_W-1:0] PULSE_RST = 14'h0000;
  // Timing: one millisecond tick at the system clock rate
  localparam int CLK_HZ = 20000000;
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  // Group output actions
  typedef enum logic [1:0] {
    ACT_HALT,
    ACT_INVERT,
    ACT_PULSE
  } grp_action_e;
endpackage : press_tally_pkg

// ==== ms_tick_gen.sv ====
// Millisecond enable pulse divider
`timescale 1ns/1ns
module ms_tick_gen
  import press_tally_pkg::*;
#(
  parameter int DIV = MS_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Tick out
  output logic tick_o
);
  logic [15:0] div_ff;

  // Free-running divider, one-cycle pulse at wrap
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_ff <= 16'h0000;
      tick_o <= 1'b0;
    end else if (div_ff == 16'(DIV - 1)) begin
      div_ff <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      div_ff <= div_ff + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule : ms_tick_gen

// ==== group_tally.sv ====
// One group tally with halt, invert or timed-pulse cam action
`timescale 1ns/1ns
module group_tally
  import press_tally_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Control from the bank
  input wire logic adv_i,
  input wire logic ms_tick_i,
  input wire logic ld_i,
  input wire logic [TALLY_W-1:0] ld_val_i,
  input wire logic halt_ack_i,
  input wire logic [TALLY_W-1:0] preset_i,
  input wire grp_action_e action_i,
  input wire logic [PULSE_W-1:0] pulse_ms_i,
  // State out
  output logic [TALLY_W-1:0] count_o,
  output logic halt_o,
  output logic cam_o
);
  logic hit;
  logic [PULSE_W-1:0] pulse_ff;

  // Preset reached on this advance; zero preset disables
  assign hit = adv_i && (preset_i != PRESET_RST) && (count_o + 1'b1 == preset_i);

  // Count with load priority
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_o <= COUNT_RST;
    end else if (ld_i) begin
      count_o <= ld_val_i;
    end else if (halt_o && halt_ack_i) begin
      count_o <= COUNT_RST;
    end else if (adv_i) begin
      count_o <= count_o + 1'b1;
    end
  end

  // Halt request, set wins over acknowledge
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      halt_o <= 1'b0;
    end else if (hit && action_i == ACT_HALT) begin
      halt_o <= 1'b1;
    end else if (halt_ack_i) begin
      halt_o <= 1'b0;
    end
  end

  // Cam output: invert or timed pulse
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cam_o <= 1'b0;
      pulse_ff <= PULSE_RST;
    end else if (hit && action_i == ACT_INVERT) begin
      cam_o <= ~cam_o;
    end else if (hit && action_i == ACT_PULSE) begin
      cam_o <= (pulse_ms_i != PULSE_RST);
      pulse_ff <= (pulse_ms_i > PULSE_MAX_MS) ? PULSE_MAX_MS : pulse_ms_i;
    end else if (action_i == ACT_PULSE && ms_tick_i && pulse_ff != PULSE_RST) begin
      pulse_ff <= pulse_ff - 1'b1;
      if (pulse_ff == 14'h0001) begin
        cam_o <= 1'b0;
      end
    end
  end

  a_invert_flip: assert property (@(posedge clock_i) disable iff (!resetn_i)
    hit && action_i == ACT_INVERT && !ld_i |=> cam_o != $past(cam_o))
    else $error("cam did not flip on invert preset");
  a_halt_raise: assert property (@(posedge clock_i) disable iff (!resetn_i)
    hit && action_i == ACT_HALT |=> halt_o)
    else $error("group halt not raised");
  c_pulse_run: cover property (@(posedge clock_i) disable iff (!resetn_i)
    hit && action_i == ACT_PULSE ##1 cam_o);
endmodule : group_tally

// ==== press_stroke_counter_bank.sv ====
// Press stroke counter bank: stroke, good-item, lifetime and group tallies
`timescale 1ns/1ns
module press_stroke_counter_bank
  import press_tally_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Press motion and faults
  input wire logic [ANGLE_W-1:0] crank_angle_i,
  input wire logic tool_loaded_i,
  input wire logic tonnage_fault_i,
  input wire logic die_fault_i,
  input wire logic process_fault_i,
  // Tool load strobe: staged settings become active
  input wire logic tool_load_i,
  // Staged settings (edited tool)
  input wire logic [TALLY_W-1:0] stg_stroke_preset_i,
  input wire logic [TALLY_W-1:0] stg_good_preset_i,
  input wire logic [TALLY_W-1:0] stg_life_preset_i,
  input wire logic [TALLY_W-1:0] stg_grp_preset_i [NUM_GROUPS],
  input wire grp_action_e stg_grp_action_i [NUM_GROUPS],
  input wire logic stg_grp_src_good_i [NUM_GROUPS],
  input wire logic [PULSE_W-1:0] stg_grp_pulse_ms_i [NUM_GROUPS],
  input wire logic [ANGLE_W-1:0] stg_main_angle_i,
  input wire logic [ANGLE_W-1:0] stg_grp_angle_i [NUM_GROUPS],
  // Count edit port
  input wire logic [2:0] edit_sel_i,
  input wire logic [TALLY_W-1:0] edit_val_i,
  input wire logic edit_stage_i,
  input wire logic edit_confirm_i,
  input wire logic edit_cancel_i,
  input wire logic edit_clear_i,
  input wire logic edit_lock_i,
  // Operator acknowledge of preset message
  input wire logic msg_ack_i,
  // Outputs
  output logic top_stop_req_o,
  output logic stroke_msg_o,
  output logic good_msg_o,
  output logic [NUM_GROUPS-1:0] grp_msg_o,
  output logic maint_flash_o,
  output logic edit_pending_o,
  output logic [8:0] cam_ch_o,
  output logic [TALLY_W-1:0] stroke_count_o,
  output logic [TALLY_W-1:0] good_count_o,
  output logic [TALLY_W-1:0] life_count_o,
  output logic [TALLY_W-1:0] grp_count_o [NUM_GROUPS]
);
  // Active settings
  logic [TALLY_W-1:0] stroke_preset_ff;
  logic [TALLY_W-1:0] good_preset_ff;
  logic [TALLY_W-1:0] life_preset_ff;
  logic [TALLY_W-1:0] grp_preset_ff [NUM_GROUPS];
  grp_action_e grp_action_ff [NUM_GROUPS];
  logic grp_src_good_ff [NUM_GROUPS];
  logic [PULSE_W-1:0] grp_pulse_ff [NUM_GROUPS];
  logic [ANGLE_W-1:0] main_angle_ff;
  logic [ANGLE_W-1:0] grp_angle_ff [NUM_GROUPS];
  // Edit staging
  logic [2:0] edit_sel_ff;
  logic [TALLY_W-1:0] edit_val_ff;
  logic apply_ld;
  logic [2:0] apply_sel;
  logic [TALLY_W-1:0] apply_val;
  // Stroke tracking
  logic [ANGLE_W-1:0] prev_angle_ff;
  logic fault_seen_ff;
  logic main_cross;
  logic [NUM_GROUPS-1:0] grp_cross;
  logic stroke_adv;
  logic good_adv;
  logic stroke_hit;
  logic good_hit;
  logic [NUM_GROUPS-1:0] grp_halt;
  logic [NUM_GROUPS-1:0] grp_cam;
  logic ms_tick;
  logic stroke_held_ff;
  logic good_held_ff;

  // Crossing of an angle: previous below, current at or above (wrap counts as new stroke)
  function automatic logic crossed(input logic [ANGLE_W-1:0] prev, input logic [ANGLE_W-1:0] cur,
                                   input logic [ANGLE_W-1:0] ang);
    crossed = (prev < ang && cur >= ang) || (prev > cur && cur >= ang);
  endfunction : crossed

  assign main_cross = crossed(prev_angle_ff, crank_angle_i, main_angle_ff);

  // Previous angle register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_angle_ff <= ANGLE_RST;
    end else begin
      prev_angle_ff <= crank_angle_i;
    end
  end

  // Fault memory for the current stroke, reset after the count point
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_seen_ff <= 1'b0;
    end else if (main_cross) begin
      fault_seen_ff <= 1'b0;
    end else if (tonnage_fault_i || die_fault_i || process_fault_i) begin
      fault_seen_ff <= 1'b1;
    end
  end

  assign stroke_adv = main_cross;
  assign good_adv = main_cross && !(fault_seen_ff || tonnage_fault_i || die_fault_i
                    || process_fault_i);

  // Activate settings on tool load only
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stroke_preset_ff <= PRESET_RST;
      good_preset_ff <= PRESET_RST;
      life_preset_ff <= PRESET_RST;
      main_angle_ff <= ANGLE_RST;
      for (int g = 0; g < NUM_GROUPS; g++) begin
        grp_preset_ff[g] <= PRESET_RST;
        grp_action_ff[g] <= ACT_HALT;
        grp_src_good_ff[g] <= 1'b0;
        grp_pulse_ff[g] <= PULSE_RST;
        grp_angle_ff[g] <= ANGLE_RST;
      end
    end else if (tool_load_i) begin
      stroke_preset_ff <= stg_stroke_preset_i;
      good_preset_ff <= stg_good_preset_i;
      life_preset_ff <= stg_life_preset_i;
      main_angle_ff <= stg_main_angle_i;
      for (int g = 0; g < NUM_GROUPS; g++) begin
        grp_preset_ff[g] <= stg_grp_preset_i[g];
        grp_action_ff[g] <= stg_grp_action_i[g];
        grp_src_good_ff[g] <= stg_grp_src_good_i[g];
        grp_pulse_ff[g] <= stg_grp_pulse_ms_i[g];
        grp_angle_ff[g] <= stg_grp_angle_i[g];
      end
    end
  end

  // Staged count edit: confirm applies, cancel discards, lock rejects
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edit_pending_o <= 1'b0;
      edit_sel_ff <= 3'h0;
      edit_val_ff <= COUNT_RST;
    end else if (edit_lock_i || edit_cancel_i || edit_confirm_i) begin
      edit_pending_o <= 1'b0;
    end else if (edit_stage_i) begin
      edit_pending_o <= 1'b1;
      edit_sel_ff <= edit_sel_i;
      edit_val_ff <= edit_val_i;
    end
  end

  // Load or clear strobe to the selected tally
  always_comb begin
    apply_ld = 1'b0;
    apply_sel = edit_sel_ff;
    apply_val = edit_val_ff;
    if (!edit_lock_i && edit_pending_o && edit_confirm_i && !edit_cancel_i) begin
      apply_ld = 1'b1;
    end else if (!edit_lock_i && edit_clear_i) begin
      apply_ld = 1'b1;
      apply_sel = edit_sel_i;
      apply_val = COUNT_RST;
    end
  end

  assign stroke_hit = stroke_adv && stroke_preset_ff != PRESET_RST
                      && stroke_count_o + 1'b1 == stroke_preset_ff;
  assign good_hit = good_adv && good_preset_ff != PRESET_RST
                    && good_count_o + 1'b1 == good_preset_ff;

  // Stroke tally
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stroke_count_o <= COUNT_RST;
    end else if (apply_ld && apply_sel == IDX_STROKE) begin
      stroke_count_o <= apply_val;
    end else if (stroke_held_ff && msg_ack_i) begin
      stroke_count_o <= COUNT_RST;
    end else if (stroke_adv) begin
      stroke_count_o <= stroke_count_o + 1'b1;
    end
  end

  // Good-item tally
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      good_count_o <= COUNT_RST;
    end else if (apply_ld && apply_sel == IDX_GOOD) begin
      good_count_o <= apply_val;
    end else if (good_held_ff && msg_ack_i) begin
      good_count_o <= COUNT_RST;
    end else if (good_adv) begin
      good_count_o <= good_count_o + 1'b1;
    end
  end

  // Lifetime tally: never self-clears
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      life_count_o <= COUNT_RST;
    end else if (apply_ld && apply_sel == IDX_LIFE) begin
      life_count_o <= apply_val;
    end else if (stroke_adv && tool_loaded_i) begin
      life_count_o <= life_count_o + 1'b1;
    end
  end

  // Maintenance indication at or past lifetime preset
  assign maint_flash_o = life_preset_ff != PRESET_RST && life_count_o >= life_preset_ff;

  // Preset messages, set wins over acknowledge
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stroke_held_ff <= 1'b0;
      good_held_ff <= 1'b0;
    end else begin
      stroke_held_ff <= stroke_hit || (stroke_held_ff && !msg_ack_i);
      good_held_ff <= good_hit || (good_held_ff && !msg_ack_i);
    end
  end

  assign stroke_msg_o = stroke_held_ff;
  assign good_msg_o = good_held_ff;
  assign grp_msg_o = grp_halt;
  assign top_stop_req_o = stroke_held_ff || good_held_ff || (|grp_halt);

  ms_tick_gen u_ms_tick (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .tick_o(ms_tick)
  );

  // Group tallies with their own angles (group zero shares the main angle)
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    logic [ANGLE_W-1:0] ang;
    logic src_adv;
    assign ang = (g == 0) ? main_angle_ff : grp_angle_ff[g];
    assign grp_cross[g] = crossed(prev_angle_ff, crank_angle_i, ang);
    assign src_adv = grp_cross[g] && (grp_src_good_ff[g] ? !(fault_seen_ff
                     || tonnage_fault_i || die_fault_i || process_fault_i) : 1'b1);
    group_tally u_grp (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .adv_i(src_adv),
      .ms_tick_i(ms_tick),
      .ld_i(apply_ld && apply_sel == IDX_GRP0 + 3'(g)),
      .ld_val_i(apply_val),
      .halt_ack_i(msg_ack_i),
      .preset_i(grp_preset_ff[g]),
      .action_i(grp_action_ff[g]),
      .pulse_ms_i(grp_pulse_ff[g]),
      .count_o(grp_count_o[g]),
      .halt_o(grp_halt[g]),
      .cam_o(grp_cam[g])
    );
  end

  // Fixed cam channel mapping
  always_comb begin
    cam_ch_o = 9'h000;
    cam_ch_o[CAM_CH_GRP0] = grp_cam[0];
    cam_ch_o[CAM_CH_GRP1] = grp_cam[1];
    cam_ch_o[CAM_CH_GRP2] = grp_cam[2];
  end

  a_stroke_stop: assert property (@(posedge clock_i) disable iff (!resetn_i)
    stroke_hit |=> top_stop_req_o && stroke_msg_o)
    else $error("stroke preset did not request stop");
  a_stroke_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
    stroke_held_ff && msg_ack_i && !apply_ld |=> stroke_count_o == COUNT_RST)
    else $error("stroke tally not cleared on ack");
  a_good_skip: assert property (@(posedge clock_i) disable iff (!resetn_i)
    main_cross && (fault_seen_ff || die_fault_i) && !apply_ld && !good_held_ff
    |=> $stable(good_count_o))
    else $error("faulted stroke counted as good");
  a_zero_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
    stroke_preset_ff == PRESET_RST && !stroke_held_ff |=> !stroke_msg_o)
    else $error("disabled tally raised message");
  a_lock_block: assert property (@(posedge clock_i) disable iff (!resetn_i)
    edit_lock_i |-> !apply_ld)
    else $error("edit applied while locked");
  a_life_adv: assert property (@(posedge clock_i) disable iff (!resetn_i)
    stroke_adv && tool_loaded_i && !apply_ld |=> life_count_o == $past(life_count_o) + 1'b1)
    else $error("lifetime tally missed stroke");
  a_load_only: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !tool_load_i |=> $stable(stroke_preset_ff) && $stable(main_angle_ff))
    else $error("settings changed without tool load");
  a_cancel_drop: assert property (@(posedge clock_i) disable iff (!resetn_i)
    edit_cancel_i |=> !edit_pending_o)
    else $error("cancelled edit still pending");
  c_stroke_stop: cover property (@(posedge clock_i) disable iff (!resetn_i)
    stroke_hit ##[1:5] msg_ack_i);
  c_maint: cover property (@(posedge clock_i) disable iff (!resetn_i) maint_flash_o);
  c_edit: cover property (@(posedge clock_i) disable iff (!resetn_i)
    edit_stage_i ##[1:5] edit_confirm_i);
endmodule : press_stroke_counter_bank

// ==== press_stop_model.sv ====
// Far-side model: press top-stop control and cam output channels
`timescale 1ns/1ns
module press_stop_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Requests from the counter bank
  input wire logic stop_req_i,
  input wire logic [8:0] cam_i,
  // Observed press state
  output logic stopped_o,
  output logic [31:0] pulse_len_o
);
  logic [31:0] run_ff;
  // Press halts at top of stroke once a stop request is seen
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) stopped_o <= 1'b0;
    else if (stop_req_i) stopped_o <= 1'b1;
  end
  // Length of the last on-time of cam channel 8
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_ff <= 32'h0;
      pulse_len_o <= 32'h0;
    end else if (cam_i[8]) begin
      run_ff <= run_ff + 32'h1;
    end else if (run_ff != 32'h0) begin
      pulse_len_o <= run_ff;
      run_ff <= 32'h0;
    end
  end
endmodule : press_stop_model

// ==== tb_press_stroke_counter_bank.sv ====
// Self-checking bench for the press stroke counter bank
`timescale 1ns/1ns
module tb_press_stroke_counter_bank;
  import press_tally_pkg::*;
  logic clock_i = 1'b0, resetn_i = 1'b0, tool_loaded_i = 1'b1, tool_load_i = 1'b0;
  logic tonnage_fault_i = 1'b0, die_fault_i = 1'b0, process_fault_i = 1'b0;
  logic [ANGLE_W-1:0] crank_angle_i = 9'h000, stg_main_angle_i = 9'h10e;
  logic [TALLY_W-1:0] stg_stroke_preset_i = '0, stg_good_preset_i = '0, stg_life_preset_i = '0;
  logic [TALLY_W-1:0] stg_grp_preset_i [NUM_GROUPS] = '{default: '0};
  grp_action_e stg_grp_action_i [NUM_GROUPS] = '{default: ACT_HALT};
  logic stg_grp_src_good_i [NUM_GROUPS] = '{default: 1'b0};
  logic [PULSE_W-1:0] stg_grp_pulse_ms_i [NUM_GROUPS] = '{default: '0};
  logic [ANGLE_W-1:0] stg_grp_angle_i [NUM_GROUPS] = '{default: 9'h10e};
  logic [2:0] edit_sel_i = 3'h0;
  logic [TALLY_W-1:0] edit_val_i = '0;
  logic edit_stage_i = 1'b0, edit_confirm_i = 1'b0, edit_cancel_i = 1'b0;
  logic edit_clear_i = 1'b0, edit_lock_i = 1'b0, msg_ack_i = 1'b0;
  logic top_stop_req_o, stroke_msg_o, good_msg_o, maint_flash_o, edit_pending_o, stopped;
  logic [NUM_GROUPS-1:0] grp_msg_o;
  logic [8:0] cam_ch_o;
  logic [TALLY_W-1:0] stroke_count_o, good_count_o, life_count_o;
  logic [TALLY_W-1:0] grp_count_o [NUM_GROUPS];
  logic [31:0] pulse_len;
  int failures = 0;
  int checked = 0;

  press_stroke_counter_bank press_stroke_counter_bank_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .crank_angle_i(crank_angle_i),
    .tool_loaded_i(tool_loaded_i), .tonnage_fault_i(tonnage_fault_i),
    .die_fault_i(die_fault_i), .process_fault_i(process_fault_i), .tool_load_i(tool_load_i),
    .stg_stroke_preset_i(stg_stroke_preset_i), .stg_good_preset_i(stg_good_preset_i),
    .stg_life_preset_i(stg_life_preset_i), .stg_grp_preset_i(stg_grp_preset_i),
    .stg_grp_action_i(stg_grp_action_i), .stg_grp_src_good_i(stg_grp_src_good_i),
    .stg_grp_pulse_ms_i(stg_grp_pulse_ms_i), .stg_main_angle_i(stg_main_angle_i),
    .stg_grp_angle_i(stg_grp_angle_i), .edit_sel_i(edit_sel_i), .edit_val_i(edit_val_i),
    .edit_stage_i(edit_stage_i), .edit_confirm_i(edit_confirm_i),
    .edit_cancel_i(edit_cancel_i), .edit_clear_i(edit_clear_i), .edit_lock_i(edit_lock_i),
    .msg_ack_i(msg_ack_i), .top_stop_req_o(top_stop_req_o), .stroke_msg_o(stroke_msg_o),
    .good_msg_o(good_msg_o), .grp_msg_o(grp_msg_o), .maint_flash_o(maint_flash_o),
    .edit_pending_o(edit_pending_o), .cam_ch_o(cam_ch_o), .stroke_count_o(stroke_count_o),
    .good_count_o(good_count_o), .life_count_o(life_count_o), .grp_count_o(grp_count_o)
  );
  press_stop_model press_stop_model_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .stop_req_i(top_stop_req_o),
    .cam_i(cam_ch_o), .stopped_o(stopped), .pulse_len_o(pulse_len)
  );

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  // Compare one value and report a mismatch
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Print the verdict and end the run
  task give_verdict();
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // Reset for three cycles, optionally make staged settings active
  task do_reset(input bit load);
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    if (load) strobe(0);
  endtask : do_reset

  // One-cycle strobe: 0 load, 1 stage, 2 confirm, 3 cancel, 4 clear, 5 ack
  task strobe(input int k);
    @(posedge clock_i);
    case (k)
      0: tool_load_i <= 1'b1;
      1: edit_stage_i <= 1'b1;
      2: edit_confirm_i <= 1'b1;
      3: edit_cancel_i <= 1'b1;
      4: edit_clear_i <= 1'b1;
      default: msg_ack_i <= 1'b1;
    endcase
    @(posedge clock_i);
    {tool_load_i, edit_stage_i, edit_confirm_i, edit_cancel_i, edit_clear_i, msg_ack_i} <= '0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask : strobe

  // One stroke 0 -> 300 deg; f 1..3 flags a fault before the crossing
  task stroke(input int f);
    @(posedge clock_i);
    crank_angle_i <= 9'h000;
    tonnage_fault_i <= (f == 1);
    die_fault_i <= (f == 2);
    process_fault_i <= (f == 3);
    repeat (2) @(posedge clock_i);
    crank_angle_i <= 9'h12c;
    {tonnage_fault_i, die_fault_i, process_fault_i} <= 3'h0;
    repeat (3) @(posedge clock_i);
    #1;
  endtask : stroke

  // Move the crank to one angle and let the tallies settle
  task turn_to(input logic [ANGLE_W-1:0] a);
    @(posedge clock_i);
    crank_angle_i <= a;
    repeat (4) @(posedge clock_i);
    #1;
  endtask : turn_to

  // Stroke preset stop, acknowledge, and settings held until reload
  task t_stroke();
    stg_stroke_preset_i <= 24'h000003;
    do_reset(1);
    stg_stroke_preset_i <= 24'h000002;
    repeat (2) stroke(0);
    chk("stroke_msg old preset", 1'b0, stroke_msg_o);
    stroke(0);
    chk("stroke_count", 24'h000003, stroke_count_o);
    chk("stroke_msg", 1'b1, stroke_msg_o);
    chk("top_stop", 1'b1, top_stop_req_o);
    chk("press stopped", 1'b1, stopped);
    chk("good_msg zero preset", 1'b0, good_msg_o);
    chk("life_count", 24'h000003, life_count_o);
    strobe(5);
    chk("stroke_count ack", 24'h000000, stroke_count_o);
    chk("stroke_msg ack", 1'b0, stroke_msg_o);
    chk("top_stop ack", 1'b0, top_stop_req_o);
  endtask : t_stroke

  // Good-item tally skips each fault kind, then stops at preset
  task t_good();
    stg_good_preset_i <= 24'h000002;
    stg_stroke_preset_i <= '0;
    do_reset(1);
    for (int f = 1; f <= 3; f++) stroke(f);
    chk("good faulted", 24'h000000, good_count_o);
    chk("stroke faulted", 24'h000003, stroke_count_o);
    repeat (2) stroke(0);
    chk("good_count", 24'h000002, good_count_o);
    chk("good_msg", 1'b1, good_msg_o);
    chk("top_stop good", 1'b1, top_stop_req_o);
    strobe(5);
    chk("good_count ack", 24'h000000, good_count_o);
  endtask : t_good

  // Lifetime tally: counts only with tool loaded, flags past preset without stopping
  task t_life();
    stg_good_preset_i <= '0;
    stg_life_preset_i <= 24'h000002;
    do_reset(1);
    tool_loaded_i <= 1'b0;
    stroke(0);
    chk("life unloaded", 24'h000000, life_count_o);
    tool_loaded_i <= 1'b1;
    repeat (3) stroke(0);
    chk("life past preset", 24'h000003, life_count_o);
    chk("maint_flash", 1'b1, maint_flash_o);
    chk("top_stop life", 1'b0, top_stop_req_o);
  endtask : t_life

  // Count edits: cancel, confirm, lock and clear
  task t_edit();
    stg_life_preset_i <= '0;
    do_reset(1);
    edit_sel_i <= IDX_GOOD;
    edit_val_i <= 24'h000005;
    strobe(1);
    chk("edit_pending", 1'b1, edit_pending_o);
    strobe(3);
    strobe(2);
    chk("good cancel", 24'h000000, good_count_o);
    strobe(1);
    strobe(2);
    chk("good confirm", 24'h000005, good_count_o);
    edit_lock_i <= 1'b1;
    edit_sel_i <= IDX_STROKE;
    strobe(1);
    strobe(2);
    chk("stroke locked", 24'h000000, stroke_count_o);
    edit_sel_i <= IDX_GOOD;
    strobe(4);
    chk("good clear locked", 24'h000005, good_count_o);
    edit_lock_i <= 1'b0;
    strobe(4);
    chk("good clear", 24'h000000, good_count_o);
    edit_sel_i <= IDX_GRP0 + 3'h2;
    edit_val_i <= 24'h000009;
    strobe(1);
    strobe(2);
    chk("grp2 confirm", 24'h000009, grp_count_o[2]);
  endtask : t_edit

  // Default and programmed increment angle, one advance per stroke
  task t_angle();
    do_reset(0);
    turn_to(9'h10d);
    chk("below default angle", 24'h000000, stroke_count_o);
    turn_to(9'h10e);
    chk("default angle", 24'h000001, stroke_count_o);
    stg_main_angle_i <= 9'h140;
    strobe(0);
    stroke(0);
    chk("below angle", 24'h000001, stroke_count_o);
    turn_to(9'h14a);
    repeat (2) @(posedge clock_i);
    #1;
    chk("held past angle", 24'h000002, stroke_count_o);
    stg_main_angle_i <= 9'h10e;
  endtask : t_angle

  // Group halt, invert and timed pulse on cam channels 6..8
  task t_groups();
    int i;
    stg_grp_preset_i <= '{24'h000002, 24'h000001, 24'h000001};
    stg_grp_action_i <= '{ACT_HALT, ACT_INVERT, ACT_PULSE};
    stg_grp_src_good_i <= '{1'b1, 1'b0, 1'b0};
    stg_grp_pulse_ms_i <= '{14'h0000, 14'h0000, 14'h0002};
    do_reset(1);
    stroke(2);
    chk("grp0 good source", 24'h000000, grp_count_o[0]);
    chk("grp1 stroke source", 24'h000001, grp_count_o[1]);
    chk("cam ch7 invert", 1'b1, cam_ch_o[7]);
    chk("cam ch8 pulse", 1'b1, cam_ch_o[8]);
    chk("cam other ch", 9'h000, {3'h0, cam_ch_o[5:0]});
    chk("cam ch6 halt", 1'b0, cam_ch_o[6]);
    repeat (2) stroke(0);
    chk("grp0 msg", 3'h1, {1'b0, grp_msg_o});
    chk("top_stop grp", 1'b1, top_stop_req_o);
    for (i = 0; i < 45000; i++) begin
      @(posedge clock_i);
      #1;
      if (cam_ch_o[8] !== 1'b1) break;
    end
    if (i == 45000) begin
      failures++;
      $display("[ERR] cam ch8 fall expected 0 seen %b", cam_ch_o[8]);
      give_verdict();
    end
    repeat (2) @(posedge clock_i);
    #1;
    chk("pulse length", 1'b1, pulse_len > 32'd20000 && pulse_len <= 32'd40002);
  endtask : t_groups

  // Main sequence
  initial begin
    do_reset(0);
    chk("cam after reset", 9'h000, cam_ch_o);
    chk("top_stop after reset", 1'b0, top_stop_req_o);
    t_stroke();
    t_good();
    t_life();
    t_edit();
    t_angle();
    t_groups();
    give_verdict();
  end
endmodule : tb_press_stroke_counter_bank
